// *** dv/code_source.sv ***
// ============================================================
// Processor code and enable source
module code_source #(parameter int HOLD = 32) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [5:0] want_code_i,
    input wire logic want_en_i,
    output logic [5:0] code_o,
    output logic en_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int held;
    // A new code waits until the last one has stood HOLD (32) clock cycles
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            code_o <= 6'h10;
            en_o <= 1'b0;
            held <= 0;
        end else begin
            en_o <= want_en_i;
            if (want_code_i != code_o && held >= HOLD) begin
                code_o <= want_code_i;
                held <= 0;
            end else if (held < HOLD) begin
                held <= held + 1;
            end
        end
    end
endmodule

// *** dv/vid_reference_sequencer_test.sv ***
module vid_reference_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, rdone, fault, uv_arm, ov_arm, fixed, en;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic [5:0] code, want_code = 6'h10;
    logic want_en = 1'b0, tsel = 1'b1, lok = 1'b1, dok = 1'b1;
    logic uv = 1'b0, ov = 1'b0, fbh = 1'b0, tres = 1'b0;
    logic [7:0] ref_lvl;
    logic [2:0] hs, ls;
    int n_fail = 0, n_compared = 0, cycles = 0, k, i;
    // Table select, code, expected reference
    logic [14:0] rows [6] = '{{1'b1, 6'h13, 8'h53}, {1'b1, 6'h12, 8'h52}, {1'b0, 6'h05, 8'h4a},
                             {1'b0, 6'h25, 8'h4c}, {1'b0, 6'h1e, 8'h7c}, {1'b1, 6'h11, 8'h51}};

    vid_reference_sequencer dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .voltage_code_bits_i(code), .table_select_i(tsel),
        .output_enable_pin_i(en), .logic_supply_ok_i(lok), .driver_supply_ok_i(dok),
        .under_voltage_cmp_i(uv), .over_voltage_cmp_i(ov), .remote_feedback_high_i(fbh),
        .trip_level_resistor_i(tres), .ref_level_o(ref_lvl), .ramp_done_o(rdone),
        .fault_flag_pin_o(fault), .under_voltage_trip_armed_o(uv_arm),
        .over_voltage_trip_armed_o(ov_arm), .trip_level_fixed_o(fixed),
        .high_side_allow_o(hs), .low_side_force_o(ls));
    code_source src (.mclk_i(mclk_i), .nrst_i(nrst_i), .want_code_i(want_code),
        .want_en_i(want_en), .code_o(code), .en_o(en));

    // ============================================================
    // Clock, timeout and helpers
    always #5 mclk_i = ~mclk_i;
    // Two soft starts dominate the run, about 50k cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            summarize();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One classic cycle; the request stands until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge mclk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge mclk_i);
        nrst_i <= 1'b1;
        settle(1);
        chk("hs_reset", hs, 3'h0);
        wb(1'b0, 4'h4, 32'h0);
        chk("period_rst", q, 32'h29a);
        wb(1'b1, 4'h4, 32'h2);
        wb(1'b0, 4'h4, 32'h0);
        chk("period_min", q, 32'h6);
        wb(1'b1, 4'h4, 32'hc);
        wb(1'b0, 4'hc, 32'h0);
        chk("unmapped", q, 32'h0);
        want_en <= 1'b1;
        for (k = 0; k < 30000 && rdone !== 1'b1; k++) @(posedge mclk_i);
        settle(1);
        chk("ss_ref", ref_lvl, 8'h50);
        chk("ss_ov", ov_arm, 1'b1);
        chk("ss_uv", uv_arm, 1'b1);
        for (i = 0; i < 6; i++) begin
            @(posedge mclk_i);
            tsel <= rows[i][14];
            want_code <= rows[i][13:8];
            for (k = 0; k < 2000 && ref_lvl !== rows[i][7:0]; k++) @(posedge mclk_i);
            settle(60);
            chk("row_ref", ref_lvl, rows[i][7:0]);
            chk("row_ov", ov_arm, 1'b1);
        end
        // A code change in mid-step must wait for the step to finish
        @(posedge mclk_i);
        want_code <= 6'h2f;
        for (k = 0; k < 500 && ref_lvl === 8'h51; k++) @(posedge mclk_i);
        want_code <= 6'h08;
        settle(8);
        chk("step_ov", ov_arm, 1'b0);
        chk("step_uv", uv_arm, 1'b0);
        for (k = 0; k < 500 && ref_lvl !== 8'h6f; k++) @(posedge mclk_i);
        chk("ignored", ref_lvl, 8'h6f);
        for (k = 0; k < 500 && ref_lvl !== 8'h48; k++) @(posedge mclk_i);
        settle(60);
        chk("resumed", ref_lvl, 8'h48);
        @(posedge mclk_i);
        uv <= 1'b1;
        for (k = 0; k < 200 && fault !== 1'b1; k++) @(posedge mclk_i);
        uv <= 1'b0;
        settle(20);
        chk("uv_fault", fault, 1'b1);
        chk("uv_hs", hs, 3'h0);
        @(posedge mclk_i);
        want_en <= 1'b0;
        want_code <= 6'h3e;
        settle(40);
        chk("en_clear", fault, 1'b0);
        chk("en_rdone", rdone, 1'b0);
        @(posedge mclk_i);
        want_en <= 1'b1;
        settle(300);
        chk("no_processor_code_hs", hs, 3'h0);
        chk("no_processor_code_rd", rdone, 1'b0);
        @(posedge mclk_i);
        want_code <= 6'h02;
        settle(40);
        chk("ss_uv_early", uv_arm, 1'b0);
        chk("ss_ov_early", ov_arm, 1'b1);
        for (k = 0; k < 30000 && rdone !== 1'b1; k++) @(posedge mclk_i);
        settle(1);
        chk("wake_ref", ref_lvl, 8'h42);
        @(posedge mclk_i);
        ov <= 1'b1;
        for (k = 0; k < 50 && fault !== 1'b1; k++) @(posedge mclk_i);
        ov <= 1'b0;
        settle(10);
        chk("ov_ls", ls, 3'h7);
        chk("ov_hs", hs, 3'h0);
        chk("ov_fault", fault, 1'b1);
        @(posedge mclk_i);
        lok <= 1'b0;
        fbh <= 1'b1;
        tres <= 1'b1;
        settle(10);
        chk("clamp_ls", ls, 3'h7);
        chk("sup_hs", hs, 3'h0);
        chk("trip_fixed", fixed, 1'b1);
        summarize();
    end
endmodule

// *** dv/vid_seq_props.sv ***
`include "vid_seq_defines.vh"

module vid_seq_props (
    input wire mclk_i,
    input wire nrst_i,
    input wire [5:0] voltage_code_bits_i,
    input wire output_enable_pin_i,
    input wire logic_supply_ok_i,
    input wire driver_supply_ok_i,
    input wire under_voltage_cmp_i,
    input wire over_voltage_cmp_i,
    input wire remote_feedback_high_i,
    input wire ramp_done_o,
    input wire fault_flag_pin_o,
    input wire under_voltage_trip_armed_o,
    input wire [`PHASES-1:0] high_side_allow_o,
    input wire [`PHASES-1:0] low_side_force_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);
    // ============================================================
    // Helper counters
    logic [15:0] ss_cnt;
    logic [7:0] uv_cnt;
    // Cycles of switching since it last stopped; saturates so code steps cannot wrap it
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ss_cnt <= 16'h0000;
            uv_cnt <= 8'h00;
        end else begin
            ss_cnt <= (high_side_allow_o == 3'h0) ? 16'h0000 : ss_cnt + {15'h0, ss_cnt != 16'hffff};
            uv_cnt <= (under_voltage_trip_armed_o && under_voltage_cmp_i) ?
                      uv_cnt + {7'h0, uv_cnt != 8'hff} : 8'h00;
        end
    end
    // ============================================================
    // Properties
    a_disable_clears_all: assert property (
        !output_enable_pin_i [*5] |-> !fault_flag_pin_o && !ramp_done_o && high_side_allow_o == 3'h0)
        else $error("enable low left the stage active");
    a_no_cpu_off: assert property (
        (voltage_code_bits_i[5:1] == 5'h1f) [*5] |-> !ramp_done_o && high_side_allow_o == 3'h0)
        else $error("no-processor code left the stage active");
    a_supply_low_off: assert property (
        (!logic_supply_ok_i || !driver_supply_ok_i) [*5] |-> high_side_allow_o == 3'h0)
        else $error("high side allowed with a supply low");
    a_clamp_low_sides: assert property (
        (!logic_supply_ok_i && remote_feedback_high_i) [*5] |-> low_side_force_o == 3'h7)
        else $error("pre-start clamp did not force low sides");
    a_uv_latches: assert property (
        uv_cnt == 8'd13 |-> ##[0:30] (fault_flag_pin_o && high_side_allow_o == 3'h0))
        else $error("sustained under-voltage did not latch a fault");
    a_ov_crowbar: assert property (
        (over_voltage_cmp_i && fault_flag_pin_o == 1'b0) [*3] ##1 over_voltage_cmp_i |->
        ##[0:6] (fault_flag_pin_o && low_side_force_o == 3'h7 && high_side_allow_o == 3'h0)
        or ##[0:6] (high_side_allow_o == 3'h0 && !fault_flag_pin_o))
        else $error("over-voltage did not crowbar");
    a_fault_holds: assert property (
        (output_enable_pin_i && logic_supply_ok_i && driver_supply_ok_i) [*4] ##0 fault_flag_pin_o
        |=> fault_flag_pin_o)
        else $error("latched fault cleared without a cycle");
    a_ramp_not_early: assert property (
        $rose(ramp_done_o) |-> ss_cnt >= 16'h2ffa)
        else $error("ramp-done rose before 2048 oscillator periods");
endmodule

bind vid_reference_sequencer vid_seq_props props (.*);

// *** rtl/vid_reference_sequencer.v ***
// Behaviour
// - Mask over/under-voltage trips during code steps
// - Table select picks step size, sampling clock
// - Fine: detect on rise, confirm on fall
// - Fine: one 12.5mV step per sample cycle
// - Ignore code while stepping; resume next rise
// - Coarse: sample at switching rate, confirm fall
// - Coarse: 25mV steps until code reached; 12.5mV step when one unit off
// - Supplies low: shut down, high sides off
// - Enable released: soft start to code
// - Enable low: clear faults, all off
// - No-processor code: disabled, ramp-done low
// - Leave no-processor code via soft start
// - Ramp reference 0V to target, 2048 periods
// - Ramp complete drives ramp-done high
// - Under-voltage armed from 0.6V reference
// - Over-voltage armed throughout soft start
// - Under-voltage over one period latches off
// - Over-voltage latches low sides on, fault
// - Trip resistor selects fixed trip level
// - Pre-start clamp: low sides on above 1.8V
`include "vid_seq_defines.vh"

module vid_reference_sequencer (
    input wire mclk_i,
    input wire nrst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire [5:0] voltage_code_bits_i,
    input wire table_select_i,
    input wire output_enable_pin_i,
    input wire logic_supply_ok_i,
    input wire driver_supply_ok_i,
    input wire under_voltage_cmp_i,
    input wire over_voltage_cmp_i,
    input wire remote_feedback_high_i,
    input wire trip_level_resistor_i,
    output reg [7:0] ref_level_o,
    output reg ramp_done_o,
    output reg fault_flag_pin_o,
    output reg under_voltage_trip_armed_o,
    output reg over_voltage_trip_armed_o,
    output reg trip_level_fixed_o,
    output reg [`PHASES-1:0] high_side_allow_o,
    output reg [`PHASES-1:0] low_side_force_o
);

    // ============================================================
    // Input synchronisers
    wire [`SYN_W-1:0] raw_in;
    reg [`SYN_W-1:0] sync_a;
    reg [`SYN_W-1:0] sync_b;

    assign raw_in = {trip_level_resistor_i, remote_feedback_high_i, over_voltage_cmp_i,
                     under_voltage_cmp_i, driver_supply_ok_i, logic_supply_ok_i,
                     output_enable_pin_i, table_select_i, voltage_code_bits_i};

    // Two flops; only sync_b is read by logic
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync_a <= {`SYN_W{1'b0}};
            sync_b <= {`SYN_W{1'b0}};
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    wire [5:0] code = sync_b[`SYN_CODE_HI:`SYN_CODE_LO];
    wire fine_sel = sync_b[`SYN_TSEL];
    wire logic_ok = sync_b[`SYN_LOGIC_OK];
    wire drv_ok = sync_b[`SYN_DRV_OK];
    wire enabled = sync_b[`SYN_OE] & logic_ok & drv_ok;
    wire uv_now = sync_b[`SYN_UV];
    wire ov_now = sync_b[`SYN_OV];
    wire no_cpu = (code[5:1] == `NO_CPU_BITS);

    // ============================================================
    // Sampling clock: rise and fall ticks from the switching period
    reg [15:0] sw_period;
    reg [15:0] div_cnt;
    reg [1:0] third_cnt;
    reg osc_tick;
    reg rise_tick;
    reg fall_tick;
    wire [15:0] sample_len;
    wire [15:0] half_len;

    // Fine table samples at three times the switching rate
    assign sample_len = fine_sel ? (sw_period / `FINE_DIV) : sw_period;
    assign half_len = {1'b0, sample_len[15:1]};

    // Period change takes effect at once; the >= compare means the counter never overruns
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_cnt <= 16'h0000;
            third_cnt <= 2'h0;
            rise_tick <= 1'b0;
            fall_tick <= 1'b0;
            osc_tick <= 1'b0;
        end else begin
            rise_tick <= 1'b0;
            fall_tick <= 1'b0;
            osc_tick <= 1'b0;
            if (div_cnt + 16'h0001 >= sample_len) begin
                div_cnt <= 16'h0000;
                rise_tick <= 1'b1;
                if (!fine_sel || third_cnt == `THIRD_LAST) begin
                    third_cnt <= 2'h0;
                    osc_tick <= 1'b1;
                end else begin
                    third_cnt <= third_cnt + 2'h1;
                end
            end else begin
                div_cnt <= div_cnt + 16'h0001;
                if (div_cnt + 16'h0001 == half_len) begin
                    fall_tick <= 1'b1;
                end
            end
        end
    end

    // ============================================================
    // Target level for the applied code
    function [7:0] code_level;
        input [5:0] c;
        input fine;
        begin
            if (fine) begin
                code_level = `LEVEL_BASE + {2'b00, c};
            end else begin
                code_level = `LEVEL_BASE + {2'b00, c[4:0], 1'b0}
                             + {6'h00, c[5], 1'b0};
            end
        end
    endfunction

    // ============================================================
    // Sequencer state machine
    localparam ST_OFF = 6'h01;
    localparam ST_SOFT = 6'h02;
    localparam ST_RUN = 6'h04;
    localparam ST_STEP = 6'h08;
    localparam ST_UVF = 6'h10;
    localparam ST_OVF = 6'h20;

    reg [5:0] state;
    reg [5:0] next_state;
    reg [7:0] ref_level;
    reg [7:0] target;
    reg [5:0] applied_code;
    reg [5:0] cand_code;
    reg cand_valid;
    reg confirmed;
    reg [10:0] ramp_cnt;
    reg uv_seen;
    reg ramp_ok;
    reg [18:0] ramp_prod;
    wire [7:0] ramp_level;
    wire [7:0] step_size;
    wire stepping;

    assign step_size = (fine_sel || ((target > ref_level ? target - ref_level :
                       ref_level - target) == `STEP_FINE)) ? `STEP_FINE : `STEP_COARSE;
    assign stepping = (state == ST_STEP);

    // Ramp reference as a fraction of the target
    always @* begin
        ramp_prod = {11'h000, target} * {8'h00, ramp_cnt};
    end
    assign ramp_level = ramp_prod[18:`RAMP_SHIFT];

    // Transition choice; disable outranks faults, no-processor code outranks all but a latched fault, faults outrank other moves
    always @* begin
        next_state = state;
        case (state)
            ST_OFF: begin
                if (enabled && !no_cpu) begin
                    next_state = ST_SOFT;
                end
            end
            ST_SOFT: begin
                if (ov_now) begin
                    next_state = ST_OVF;
                end else if (uv_now && uv_seen && osc_tick && ramp_level >= `LEVEL_UV_ARM) begin
                    next_state = ST_UVF;
                end else if (osc_tick && ramp_cnt == `RAMP_LAST) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (ov_now) begin
                    next_state = ST_OVF;
                end else if (uv_now && uv_seen && osc_tick) begin
                    next_state = ST_UVF;
                end else if (rise_tick && confirmed) begin
                    next_state = ST_STEP;
                end
            end
            ST_STEP: begin
                if (rise_tick && ref_level == target) begin
                    next_state = ST_RUN;
                end
            end
            ST_UVF: next_state = ST_UVF;
            ST_OVF: next_state = ST_OVF;
            default: next_state = ST_OFF;
        endcase
        if (!enabled) begin
            next_state = ST_OFF;
        end else if (no_cpu && (state == ST_OFF || state == ST_SOFT ||
                     state == ST_RUN || state == ST_STEP)) begin
            next_state = ST_OFF;
        end
    end

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= ST_OFF;
        end else begin
            state <= next_state;
        end
    end

    // ============================================================
    // Code monitor: detect on rise, confirm on the following fall
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            applied_code <= 6'h00;
            cand_code <= 6'h00;
            cand_valid <= 1'b0;
            confirmed <= 1'b0;
            target <= 8'h00;
        end else if (state != ST_RUN) begin
            cand_valid <= 1'b0;
            confirmed <= 1'b0;
            if (state == ST_OFF) begin
                applied_code <= code;
                target <= code_level(code, fine_sel);
            end
        end else if (!confirmed) begin
            // Changes during a step are seen at the first rise back in RUN: monitor runs in RUN only
            if (rise_tick) begin
                cand_valid <= (code != applied_code);
                cand_code <= code;
            end else if (fall_tick && cand_valid) begin
                cand_valid <= 1'b0;
                if (code == cand_code) begin
                    confirmed <= 1'b1;
                    applied_code <= cand_code;
                    target <= code_level(cand_code, fine_sel);
                end
            end
        end else if (rise_tick) begin
            confirmed <= 1'b0;
        end
    end

    // ============================================================
    // Reference stepping and soft-start ramp
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_level <= 8'h00;
            ramp_cnt <= 11'h000;
            ramp_ok <= 1'b0;
        end else begin
            case (state)
                ST_SOFT: begin
                    ref_level <= ramp_level;
                    if (osc_tick && ramp_cnt != `RAMP_LAST) begin
                        ramp_cnt <= ramp_cnt + 11'h001;
                    end
                    if (osc_tick && ramp_cnt == `RAMP_LAST) begin
                        ramp_ok <= 1'b1;
                        ref_level <= target;
                    end
                end
                ST_RUN: begin
                    // First step lands on the rise tick that leaves RUN
                    if (rise_tick && confirmed && ref_level < target) begin
                        ref_level <= ref_level + step_size;
                    end else if (rise_tick && confirmed && ref_level > target) begin
                        ref_level <= ref_level - step_size;
                    end
                end
                ST_STEP: begin
                    if (rise_tick && ref_level < target) begin
                        ref_level <= ref_level + step_size;
                    end else if (rise_tick && ref_level > target) begin
                        ref_level <= ref_level - step_size;
                    end
                end
                ST_OFF: begin
                    ref_level <= 8'h00;
                    ramp_cnt <= 11'h000;
                    ramp_ok <= 1'b0;
                end
                default: ref_level <= ref_level;
            endcase
        end
    end

    // Under-voltage must persist across a full oscillator period
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            uv_seen <= 1'b0;
        end else if (!uv_now || stepping || state == ST_OFF) begin
            uv_seen <= 1'b0;
        end else if (osc_tick) begin
            uv_seen <= 1'b1;
        end
    end

    // ============================================================
    // Registered outputs
    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_level_o <= 8'h00;
            ramp_done_o <= 1'b0;
            fault_flag_pin_o <= 1'b0;
            under_voltage_trip_armed_o <= 1'b0;
            over_voltage_trip_armed_o <= 1'b0;
            trip_level_fixed_o <= 1'b0;
        end else begin
            ref_level_o <= ref_level;
            ramp_done_o <= ramp_ok && (state == ST_RUN || state == ST_STEP);
            fault_flag_pin_o <= (state == ST_UVF || state == ST_OVF);
            under_voltage_trip_armed_o <= (state == ST_RUN) ||
                (state == ST_SOFT && ramp_level >= `LEVEL_UV_ARM);
            over_voltage_trip_armed_o <= (state == ST_RUN || state == ST_SOFT);
            trip_level_fixed_o <= sync_b[`SYN_TRIP_RES];
        end
    end

    // Per-phase gate permissions; crowbar and pre-start clamp force low sides
    genvar ph;
    generate
        for (ph = 0; ph < `PHASES; ph = ph + 1) begin : phase_gates
            always @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    high_side_allow_o[ph] <= 1'b0;
                    low_side_force_o[ph] <= 1'b0;
                end else begin
                    high_side_allow_o[ph] <= (state == ST_SOFT || state == ST_RUN ||
                                              state == ST_STEP);
                    low_side_force_o[ph] <= (state == ST_OVF) ||
                        (!logic_ok && sync_b[`SYN_FB_HIGH]);
                end
            end
        end
    endgenerate

    // ============================================================
    // Wishbone classic slave: one-wait-state ack
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            sw_period <= `PERIOD_RESET;
        end else begin
            wb_ack_o <= bus_req;
            if (bus_req && wb_we_i && wb_adr_i == `ADDR_PERIOD) begin
                // Too short a period would starve the fall tick
                if (wb_sel_i[0]) begin
                    sw_period[7:0] <= wb_dat_i[7:0];
                end
                if (wb_sel_i[1]) begin
                    sw_period[15:8] <= wb_dat_i[15:8];
                end
            end else if (sw_period < `PERIOD_MIN) begin
                sw_period <= `PERIOD_MIN;
            end
            if (bus_req && !wb_we_i) begin
                case (wb_adr_i)
                    `ADDR_STATUS: wb_dat_o <= {20'h00000, applied_code, state};
                    `ADDR_PERIOD: wb_dat_o <= {16'h0000, sw_period};
                    `ADDR_LEVELS: wb_dat_o <= {5'h00, ramp_cnt, target, ref_level};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end

endmodule

// *** rtl/vid_seq_defines.vh ***
`ifndef VID_SEQ_DEFINES_VH
`define VID_SEQ_DEFINES_VH

// ============================================================
// Register map (byte addresses, one 32-bit word each)
`define ADDR_STATUS 4'h0
`define ADDR_PERIOD 4'h4
`define ADDR_LEVELS 4'h8

// ============================================================
// Reset values and field sizes
`define PERIOD_RESET 16'h029a
`define PERIOD_MIN 16'h0006
`define PHASES 3
`define FINE_DIV 16'h0003
`define THIRD_LAST 2'h2

// ============================================================
// Reference levels in 12.5 mV units
`define LEVEL_BASE 8'h40
`define LEVEL_UV_ARM 8'h30
`define STEP_FINE 8'h01
`define STEP_COARSE 8'h02

// ============================================================
// Soft-start ramp: 2048 oscillator periods
`define RAMP_LAST 11'h7ff
`define RAMP_SHIFT 11

// ============================================================
// Synchroniser vector layout
`define SYN_W 14
`define SYN_CODE_LO 0
`define SYN_CODE_HI 5
`define SYN_TSEL 6
`define SYN_OE 7
`define SYN_LOGIC_OK 8
`define SYN_DRV_OK 9
`define SYN_UV 10
`define SYN_OV 11
`define SYN_FB_HIGH 12
`define SYN_TRIP_RES 13

`define NO_CPU_BITS 5'h1f

`endif
